//--- src/fmsp_baud.sv
`timescale 1ns/1ps
`default_nettype none
`include "fmsp_map.svh"
module fmsp_baud
  import fmsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Timer 1 setup
  input wire logic timer1_fast_clock,
  input wire logic timer1_external,
  input wire logic [7:0] timer1_reload_high,
  input wire logic timer1_input_pin,
  // Timer 2 setup
  input wire logic timer2_run,
  input wire logic timer2_external_select,
  input wire logic [15:0] timer2_reload,
  input wire logic timer2_input_pin,
  // Overflow pulses
  output logic t1_overflow,
  output logic t2_overflow
);

  logic [3:0] pre_q;
  logic pin1_q, pin2_q, half_q;
  logic [7:0] t1_q;
  logic [15:0] t2_q;
  logic t1_inc, t2_inc;

  // ----------------------------------------
  // Prescalers and pin edges
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_q <= 4'h0;
      half_q <= 1'b0;
      pin1_q <= 1'b1;
      pin2_q <= 1'b1;
    end else begin
      pre_q <= (pre_q == `FMSP_T1_DIV_LAST) ? 4'h0 : pre_q + 4'h1;
      half_q <= ~half_q;
      pin1_q <= timer1_input_pin;
      pin2_q <= timer2_input_pin;
    end
  end

  assign t1_inc = timer1_external ? (pin1_q & ~timer1_input_pin) :
                  timer1_fast_clock ? 1'b1 : (pre_q == `FMSP_T1_DIV_LAST);

  assign t2_inc = timer2_external_select ? (pin2_q & ~timer2_input_pin) : half_q;

  // ----------------------------------------
  // Timer 1, 8-bit auto-reload
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      t1_q <= `FMSP_RST_BYTE;
      t1_overflow <= 1'b0;
    end else begin
      t1_overflow <= 1'b0;
      if (t1_inc) begin
        if (t1_q == 8'hff) begin
          t1_q <= timer1_reload_high;
          t1_overflow <= 1'b1;
        end else begin
          t1_q <= t1_q + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Timer 2, baud generator only; no interrupt path
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      t2_q <= `FMSP_RST_WORD;
      t2_overflow <= 1'b0;
    end else begin
      t2_overflow <= 1'b0;
      if (!timer2_run) begin
        t2_q <= timer2_reload;
      end else if (t2_inc) begin
        if (t2_q == 16'hffff) begin
          t2_q <= timer2_reload;
          t2_overflow <= 1'b1;
        end else begin
          t2_q <= t2_q + 16'h0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- src/fmsp_map.svh
// Contract
// - Received byte held apart from receive shifter
// - Buffer reads receive data, writes transmit
// - Done flags cleared only by software
// - Four modes: shift, 8-bit, 9-bit fixed, 9-bit timed
// - Mode 0 master, data on rx, clock on tx
// - Mode 0 sends eight bits, flag after eighth
// - Mode 0 receives while enabled and flag clear
// - Mode 0 receive pin is open-drain
// - Mode 1 frame: start, eight bits, stop
// - Async transmit flag at stop-bit start
// - Async receive any time while enabled
// - Mode 1 loads byte and stop if accepted
// - Each Timer 2 overflow gives one baud pulse; Timer 1 gives one per two overflows, one per overflow with doubler
// - Timer 1 divisor 32 or 16, Timer 2 16
// - Timer 1 overflows every 256 minus reload counts
// - Timer 2 at half clock, 65536 minus reload
// - Timer 2 selection forces baud generator mode
// - Mode 2 frame carries programmable ninth bit
// - Mode 2 loads byte and ninth if accepted
// - Interrupt requested when enabled and flag set
// - Mode 2 rate is clock over 64 or 32
// - Mode 3 is mode 2 with timer rate
// - Multiprocessor filter sits at control bit 5
`ifndef FMSP_MAP_SVH
`define FMSP_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FMSP_OFS_SCTRL 8'h00
`define FMSP_OFS_SERIAL_BUFFER 8'h04
`define FMSP_OFS_PCTRL 8'h08
`define FMSP_OFS_CKCTRL 8'h0c
`define FMSP_OFS_TMODE 8'h10
`define FMSP_OFS_T1RELOAD 8'h14
`define FMSP_OFS_T2CTRL 8'h18
`define FMSP_OFS_T2RELOAD 8'h1c
`define FMSP_OFS_IRQEN 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FMSP_SC_MODE_HI 7
`define FMSP_SC_MODE_LO 6
`define FMSP_SC_MPF 5
`define FMSP_SC_REN 4
`define FMSP_SC_TB8 3
`define FMSP_SC_RB8 2
`define FMSP_SC_TI 1
`define FMSP_SC_RI 0
`define FMSP_PC_DOUBLER 7
`define FMSP_CK_T1FAST 4
`define FMSP_TM_T1EXT 6
`define FMSP_T2_RCLK 5
`define FMSP_T2_TX_CLOCK_FROM_TIMER2 4
`define FMSP_T2_EXT 1
`define FMSP_IE_EN 0

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define FMSP_RST_BYTE 8'h00
`define FMSP_RST_WORD 16'h0000
`define FMSP_M0_LAST 4'hb
`define FMSP_M0_HALF 4'h6
`define FMSP_T1_DIV_LAST 4'hb
`define FMSP_OVS_LAST 4'hf
`define FMSP_OVS_MID 4'h7
`define FMSP_LAST8 4'h9
`define FMSP_LAST9 4'ha
`define FMSP_BIT_LAST 3'h7

`endif

//--- src/fmsp_pkg.sv
package fmsp_pkg;

  // Serial mode selected by the two top control bits
  typedef enum logic [1:0] {
    MODE0_SHIFT,
    MODE1_UART8,
    MODE2_UART9_FIXED,
    MODE3_UART9_TIMED
  } fmsp_mode_t;

  typedef enum logic {TX_IDLE, TX_SEND} fmsp_tx_state_t;

  typedef enum logic {RX_IDLE, RX_RECV} fmsp_rx_state_t;

  typedef enum logic [1:0] {M0_IDLE, M0_TX, M0_RX, M0_DONE} fmsp_m0_state_t;

endpackage

//--- src/fmsp_uart.sv
`timescale 1ns/1ps
`default_nettype none
`include "fmsp_map.svh"
module fmsp_uart
  import fmsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial pins
  input wire logic rx_pin_i,
  output logic rx_pin_o,
  output logic rx_pin_oe,
  output logic tx_pin,
  // Timer clock pins
  input wire logic timer1_input_pin,
  input wire logic timer2_input_pin,
  // Interrupt request
  output logic irq
);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic ap_valid;
  logic wr_pend_q, rd_pend_q;
  logic [7:0] addr_q;
  logic [31:0] rd_data;

  function automatic logic wr_hit(input logic pend, input logic [7:0] a,
                                  input logic [7:0] ofs);
    wr_hit = pend && (a == ofs);
  endfunction

  assign ap_valid = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_pend_q;
  assign hresp = 1'b0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= ap_valid & hwrite;
      rd_pend_q <= ap_valid & ~hwrite;
      if (ap_valid) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  // Read data captured in the single wait state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata <= rd_data;
    end
  end

  logic sctrl_wr, serial_buffer_wr, pctrl_wr, ckctrl_wr, tmode_wr;
  logic t1r_wr, t2c_wr, t2r_wr, ie_wr;
  assign sctrl_wr = wr_hit(wr_pend_q, addr_q, `FMSP_OFS_SCTRL);
  assign serial_buffer_wr = wr_hit(wr_pend_q, addr_q, `FMSP_OFS_SERIAL_BUFFER);
  assign pctrl_wr = wr_hit(wr_pend_q, addr_q, `FMSP_OFS_PCTRL);
  assign ckctrl_wr = wr_hit(wr_pend_q, addr_q, `FMSP_OFS_CKCTRL);
  assign tmode_wr = wr_hit(wr_pend_q, addr_q, `FMSP_OFS_TMODE);
  assign t1r_wr = wr_hit(wr_pend_q, addr_q, `FMSP_OFS_T1RELOAD);
  assign t2c_wr = wr_hit(wr_pend_q, addr_q, `FMSP_OFS_T2CTRL);
  assign t2r_wr = wr_hit(wr_pend_q, addr_q, `FMSP_OFS_T2RELOAD);
  assign ie_wr = wr_hit(wr_pend_q, addr_q, `FMSP_OFS_IRQEN);

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  fmsp_mode_t mode_q;
  logic multiproc_filter_q, rx_enable_q, tx_ninth_bit_q;
  logic baud_doubler_q, timer1_fast_clock_q, timer1_external_q;
  logic rx_clock_from_timer2_q, tx_clock_from_timer2_q;
  logic timer2_external_select_q, irq_enable_q;
  logic [7:0] timer1_reload_high_q;
  logic [15:0] timer2_reload_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= MODE0_SHIFT;
      multiproc_filter_q <= 1'b0;
      rx_enable_q <= 1'b0;
      tx_ninth_bit_q <= 1'b0;
    end else if (sctrl_wr) begin
      mode_q <= fmsp_mode_t'(hwdata[`FMSP_SC_MODE_HI:`FMSP_SC_MODE_LO]);
      multiproc_filter_q <= hwdata[`FMSP_SC_MPF];
      rx_enable_q <= hwdata[`FMSP_SC_REN];
      tx_ninth_bit_q <= hwdata[`FMSP_SC_TB8];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      baud_doubler_q <= 1'b0;
      timer1_fast_clock_q <= 1'b0;
      timer1_external_q <= 1'b0;
      timer1_reload_high_q <= `FMSP_RST_BYTE;
    end else begin
      if (pctrl_wr) begin
        baud_doubler_q <= hwdata[`FMSP_PC_DOUBLER];
      end
      if (ckctrl_wr) begin
        timer1_fast_clock_q <= hwdata[`FMSP_CK_T1FAST];
      end
      if (tmode_wr) begin
        timer1_external_q <= hwdata[`FMSP_TM_T1EXT];
      end
      if (t1r_wr) begin
        timer1_reload_high_q <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_clock_from_timer2_q <= 1'b0;
      tx_clock_from_timer2_q <= 1'b0;
      timer2_external_select_q <= 1'b0;
      timer2_reload_q <= `FMSP_RST_WORD;
      irq_enable_q <= 1'b0;
    end else begin
      if (t2c_wr) begin
        rx_clock_from_timer2_q <= hwdata[`FMSP_T2_RCLK];
        tx_clock_from_timer2_q <= hwdata[`FMSP_T2_TX_CLOCK_FROM_TIMER2];
        timer2_external_select_q <= hwdata[`FMSP_T2_EXT];
      end
      if (t2r_wr) begin
        timer2_reload_q <= hwdata[15:0];
      end
      if (ie_wr) begin
        irq_enable_q <= hwdata[`FMSP_IE_EN];
      end
    end
  end

  // ----------------------------------------
  // Baud timing
  // ----------------------------------------
  logic t1_ovf, t2_ovf;
  logic [1:0] m2_cnt_q;
  logic m2_tick, rx_half_q, tx_half_q, rx_src, tx_src, rx_tick, tx_tick;

  fmsp_baud u_baud (
    .clk(clk),
    .nrst(nrst),
    .timer1_fast_clock(timer1_fast_clock_q),
    .timer1_external(timer1_external_q),
    .timer1_reload_high(timer1_reload_high_q),
    .timer1_input_pin(timer1_input_pin),
    .timer2_run(rx_clock_from_timer2_q | tx_clock_from_timer2_q),
    .timer2_external_select(timer2_external_select_q),
    .timer2_reload(timer2_reload_q),
    .timer2_input_pin(timer2_input_pin),
    .t1_overflow(t1_ovf),
    .t2_overflow(t2_ovf)
  );

  // Sixteen-times oversampling tick for one direction
  function automatic logic tick16(input fmsp_mode_t m, input logic use_t2,
                                  input logic src, input logic half,
                                  input logic dbl, input logic fixed_tick);
    if (m == MODE2_UART9_FIXED) begin
      tick16 = fixed_tick;
    end else begin
      tick16 = src & (use_t2 | dbl | half);
    end
  endfunction

  assign rx_src = rx_clock_from_timer2_q ? t2_ovf : t1_ovf;
  assign tx_src = tx_clock_from_timer2_q ? t2_ovf : t1_ovf;
  // fixed rate clock over 64 or 32
  assign m2_tick = baud_doubler_q ? m2_cnt_q[0] : (m2_cnt_q == 2'h3);
  // extra halving for slow timer 1
  assign rx_tick = tick16(mode_q, rx_clock_from_timer2_q, rx_src, rx_half_q,
                          baud_doubler_q, m2_tick);
  assign tx_tick = tick16(mode_q, tx_clock_from_timer2_q, tx_src, tx_half_q,
                          baud_doubler_q, m2_tick);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      m2_cnt_q <= 2'h0;
      rx_half_q <= 1'b0;
      tx_half_q <= 1'b0;
    end else begin
      m2_cnt_q <= m2_cnt_q + 2'h1;
      if (rx_src) begin
        rx_half_q <= ~rx_half_q;
      end
      if (tx_src) begin
        tx_half_q <= ~tx_half_q;
      end
    end
  end

  logic nine_bit;
  logic [3:0] frame_last;
  // modes 2 and 3 share frame
  assign nine_bit = mode_q[1];
  assign frame_last = nine_bit ? `FMSP_LAST9 : `FMSP_LAST8;

  // ----------------------------------------
  // Asynchronous transmitter
  // ----------------------------------------
  fmsp_tx_state_t tx_st_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_bit_q, tx_sub_q;
  logic tx_ti_set;

  assign tx_ti_set = (tx_st_q == TX_SEND) && tx_tick && (tx_sub_q == `FMSP_OVS_LAST) &&
                     (tx_bit_q == frame_last - 4'h1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= 11'h7ff;
      tx_bit_q <= 4'h0;
      tx_sub_q <= 4'h0;
    end else if (serial_buffer_wr && mode_q != MODE0_SHIFT) begin
      tx_st_q <= TX_SEND;
      tx_sh_q <= {1'b1, nine_bit ? tx_ninth_bit_q : 1'b1, hwdata[7:0], 1'b0};
      tx_bit_q <= 4'h0;
      tx_sub_q <= 4'h0;
    end else if (tx_st_q == TX_SEND && tx_tick) begin
      tx_sub_q <= tx_sub_q + 4'h1;
      if (tx_sub_q == `FMSP_OVS_LAST) begin
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        if (tx_bit_q == frame_last) begin
          tx_st_q <= TX_IDLE;
        end else begin
          tx_bit_q <= tx_bit_q + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Asynchronous receiver
  // ----------------------------------------
  fmsp_rx_state_t rx_st_q;
  logic [8:0] rx_sh_q;
  logic [3:0] rx_bit_q, rx_sub_q;
  logic rx_prev_q, rx_sample, rx_finish, rx_ninth_c, rx_load;
  logic [7:0] rx_data_c;
  logic ri_q;

  assign rx_sample = (rx_st_q == RX_RECV) && rx_tick && (rx_sub_q == `FMSP_OVS_MID);
  assign rx_finish = rx_sample && (rx_bit_q == frame_last);
  assign rx_data_c = nine_bit ? rx_sh_q[7:0] : rx_sh_q[8:1];
  assign rx_ninth_c = nine_bit ? rx_sh_q[8] : rx_pin_i;
  // accept when flag clear and filter met
  assign rx_load = rx_finish & ~ri_q & (~multiproc_filter_q | rx_ninth_c);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_pin_i;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_st_q <= RX_IDLE;
      rx_sh_q <= 9'h000;
      rx_bit_q <= 4'h0;
      rx_sub_q <= 4'h0;
    end else if (!rx_enable_q || mode_q == MODE0_SHIFT) begin
      rx_st_q <= RX_IDLE;
    end else begin
      unique case (rx_st_q)
        RX_IDLE: begin
          if (rx_prev_q && !rx_pin_i) begin
            rx_st_q <= RX_RECV;
            rx_bit_q <= 4'h0;
            rx_sub_q <= 4'h0;
          end
        end
        RX_RECV: begin
          if (rx_tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
          end
          if (rx_sample) begin
            if (rx_bit_q == 4'h0 && rx_pin_i) begin
              rx_st_q <= RX_IDLE;
            end else if (rx_finish) begin
              rx_st_q <= RX_IDLE;
            end else begin
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q != 4'h0) begin
                rx_sh_q <= {rx_pin_i, rx_sh_q[8:1]};
              end
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Mode 0 shift engine
  // ----------------------------------------
  fmsp_m0_state_t m0_st_q;
  logic [7:0] m0_sh_q;
  logic [3:0] m0_cnt_q;
  logic [2:0] m0_bit_q;
  logic m0_edge, m0_ti_set, m0_ri_set;

  assign m0_edge = (m0_cnt_q == `FMSP_M0_LAST);
  // flag at end of eighth bit
  assign m0_ti_set = (m0_st_q == M0_TX) && m0_edge && (m0_bit_q == `FMSP_BIT_LAST);
  // flag one cycle after last bit
  assign m0_ri_set = (m0_st_q == M0_DONE);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      m0_st_q <= M0_IDLE;
      m0_sh_q <= 8'h00;
      m0_cnt_q <= 4'h0;
      m0_bit_q <= 3'h0;
    end else if (mode_q != MODE0_SHIFT) begin
      m0_st_q <= M0_IDLE;
    end else begin
      unique case (m0_st_q)
        M0_IDLE: begin
          m0_cnt_q <= 4'h0;
          m0_bit_q <= 3'h0;
          if (serial_buffer_wr) begin
            m0_st_q <= M0_TX;
            m0_sh_q <= hwdata[7:0];
          end else if (rx_enable_q && !ri_q) begin
            m0_st_q <= M0_RX;
          end
        end
        M0_TX, M0_RX: begin
          m0_cnt_q <= m0_edge ? 4'h0 : m0_cnt_q + 4'h1;
          if (m0_edge) begin
            m0_sh_q <= {(m0_st_q == M0_RX) ? rx_pin_i : 1'b0, m0_sh_q[7:1]};
            m0_bit_q <= m0_bit_q + 3'h1;
            if (m0_bit_q == `FMSP_BIT_LAST) begin
              m0_st_q <= (m0_st_q == M0_RX) ? M0_DONE : M0_IDLE;
            end
          end
        end
        M0_DONE: begin
          m0_st_q <= M0_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Receive holding register and flags
  // ----------------------------------------
  logic [7:0] rx_buf_q;
  logic rx_ninth_bit_q, ti_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_buf_q <= `FMSP_RST_BYTE;
    end else if (rx_load) begin
      rx_buf_q <= rx_data_c;
    end else if (m0_ri_set) begin
      rx_buf_q <= m0_sh_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_ninth_bit_q <= 1'b0;
    end else if (rx_load) begin
      rx_ninth_bit_q <= rx_ninth_c;
    end else if (sctrl_wr) begin
      rx_ninth_bit_q <= hwdata[`FMSP_SC_RB8];
    end
  end

  // hardware only sets, set beats clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ti_q <= 1'b0;
      ri_q <= 1'b0;
    end else begin
      ti_q <= tx_ti_set | m0_ti_set | (sctrl_wr ? hwdata[`FMSP_SC_TI] : ti_q);
      ri_q <= rx_load | m0_ri_set | (sctrl_wr ? hwdata[`FMSP_SC_RI] : ri_q);
    end
  end

  assign irq = irq_enable_q & (ti_q | ri_q);

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  logic m0_active;
  assign m0_active = (m0_st_q == M0_TX) || (m0_st_q == M0_RX);

  always_comb begin
    if (mode_q == MODE0_SHIFT) begin
      tx_pin = ~(m0_active && (m0_cnt_q < `FMSP_M0_HALF));
    end else begin
      tx_pin = (tx_st_q == TX_SEND) ? tx_sh_q[0] : 1'b1;
    end
  end

  assign rx_pin_o = 1'b0;
  assign rx_pin_oe = (mode_q == MODE0_SHIFT) && (m0_st_q == M0_TX) && !m0_sh_q[0];

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (addr_q)
      `FMSP_OFS_SCTRL: begin
        rd_data[7:6] = mode_q;
        rd_data[`FMSP_SC_MPF] = multiproc_filter_q;
        rd_data[`FMSP_SC_REN] = rx_enable_q;
        rd_data[`FMSP_SC_TB8] = tx_ninth_bit_q;
        rd_data[`FMSP_SC_RB8] = rx_ninth_bit_q;
        rd_data[`FMSP_SC_TI] = ti_q;
        rd_data[`FMSP_SC_RI] = ri_q;
      end
      `FMSP_OFS_SERIAL_BUFFER: rd_data[7:0] = rx_buf_q;
      `FMSP_OFS_PCTRL: rd_data[`FMSP_PC_DOUBLER] = baud_doubler_q;
      `FMSP_OFS_CKCTRL: rd_data[`FMSP_CK_T1FAST] = timer1_fast_clock_q;
      `FMSP_OFS_TMODE: rd_data[`FMSP_TM_T1EXT] = timer1_external_q;
      `FMSP_OFS_T1RELOAD: rd_data[7:0] = timer1_reload_high_q;
      `FMSP_OFS_T2CTRL: begin
        rd_data[`FMSP_T2_RCLK] = rx_clock_from_timer2_q;
        rd_data[`FMSP_T2_TX_CLOCK_FROM_TIMER2] = tx_clock_from_timer2_q;
        rd_data[`FMSP_T2_EXT] = timer2_external_select_q;
      end
      `FMSP_OFS_T2RELOAD: rd_data[15:0] = timer2_reload_q;
      `FMSP_OFS_IRQEN: rd_data[`FMSP_IE_EN] = irq_enable_q;
      default: rd_data = 32'h0000_0000;
    endcase
  end

endmodule
`default_nettype wire

//--- tb/fmsp_peer.sv
`timescale 1ns/1ps
`default_nettype none
module fmsp_peer (
  // Clock and line
  input wire logic clk,
  output logic line
);
  initial line = 1'b1;
  task automatic send(input logic [7:0] d, input logic n9);
    logic [10:0] f;
    f = {1'b1, n9, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line <= f[i];
      repeat (32) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

//--- tb/fmsp_uart_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fmsp_uart_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Serial pins
  input wire logic rx_pin_o,
  input wire logic rx_pin_oe,
  input wire logic tx_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic rd_take;
  logic wr_take;
  assign rd_take = hsel & htrans[1] & hready & !hwrite;
  assign wr_take = hsel & htrans[1] & hready & hwrite;
  chk_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_fast: assert property (wr_take |=> hreadyout)
    else $error("write stalled");
  chk_data_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a read");
  chk_okay_resp: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_drain_only: assert property (rx_pin_o == 1'b0)
    else $error("receive pin driven high");
  chk_clk_low: assert property ($fell(tx_pin) |-> !tx_pin [*6])
    else $error("shift clock low phase short");
  chk_clk_high: assert property ($rose(tx_pin) |-> tx_pin [*6])
    else $error("shift clock high phase short");
  chk_oe_bit: assert property ($rose(rx_pin_oe) |-> ##[0:11] $fell(tx_pin))
    else $error("data pulled low without shift clock");
endmodule
bind fmsp_uart fmsp_uart_chk u_chk (.clk(clk), .nrst(nrst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .rx_pin_o(rx_pin_o), .rx_pin_oe(rx_pin_oe), .tx_pin(tx_pin));
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fmsp_map.svh"
module tb_top;
  logic clk, nrst, hsel, hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, v;
  wire logic hreadyout, hresp, rx_pin_o, rx_pin_oe, tx_pin, irq, peer_line, rx_line;
  wire logic [31:0] hrdata;
  int n_fail = 0;
  int compares = 0;
  assign rx_line = rx_pin_oe ? rx_pin_o : peer_line;
  fmsp_uart dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_pin_i(rx_line),
    .rx_pin_o(rx_pin_o), .rx_pin_oe(rx_pin_oe), .tx_pin(tx_pin),
    .timer1_input_pin(1'b0), .timer2_input_pin(1'b0), .irq(irq));
  fmsp_peer peer (.clk(clk), .line(peer_line));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(v, e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rd(`FMSP_OFS_SCTRL, 32'h0);
    rd(8'h40, 32'h0);
    chk({31'h0, tx_pin}, 32'h1);
  endtask
  task t_m0_tx;
    logic [31:0] b;
    b = 32'h0;
    fork
      wr(`FMSP_OFS_SERIAL_BUFFER, 32'h5a);
      for (int i = 0; i < 8; i++) begin
        @(negedge tx_pin);
        @(posedge tx_pin);
        b[i] = rx_line;
      end
    join
    chk(b, 32'h5a);
    repeat (12) @(posedge clk);
    rd(`FMSP_OFS_SCTRL, 32'h02);
  endtask
  task t_m0_rx;
    wr(`FMSP_OFS_SCTRL, 32'h10);
    repeat (130) @(posedge clk);
    rd(`FMSP_OFS_SCTRL, 32'h11);
    rd(`FMSP_OFS_SERIAL_BUFFER, 32'hff);
  endtask
  task t_tx(input logic [31:0] sc, input int bt);
    logic [31:0] b;
    b = 32'h0;
    wr(`FMSP_OFS_SCTRL, sc);
    fork
      wr(`FMSP_OFS_SERIAL_BUFFER, 32'ha5);
      begin
        @(negedge tx_pin);
        repeat (bt / 2) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
          if (i == 10) rd(`FMSP_OFS_SCTRL, sc | 32'h2);
          b[i] = tx_pin;
          repeat (bt) @(posedge clk);
        end
      end
    join
    chk(b, 32'h74a);
    rd(`FMSP_OFS_SCTRL, sc | 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(`FMSP_OFS_SCTRL, sc | 32'h10);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task rx_case(input logic [7:0] d, input logic n9, input logic [31:0] eb, input logic [31:0] es);
    peer.send(d, n9);
    repeat (8) @(posedge clk);
    rd(`FMSP_OFS_SERIAL_BUFFER, eb);
    rd(`FMSP_OFS_SCTRL, es);
  endtask
  task t_m2_rx;
    rx_case(8'h3c, 1'b1, 32'h3c, 32'h9d);
    rx_case(8'hc3, 1'b0, 32'h3c, 32'h9d);
    wr(`FMSP_OFS_SCTRL, 32'hb8);
    rx_case(8'h77, 1'b0, 32'h3c, 32'hb8);
    rx_case(8'h66, 1'b1, 32'h66, 32'hbd);
  endtask
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_m0_tx;
    t_m0_rx;
    wr(`FMSP_OFS_IRQEN, 32'h1);
    t_tx(32'h88, 64);
    wr(`FMSP_OFS_PCTRL, 32'h80);
    t_tx(32'h88, 32);
    t_m2_rx;
    wr(`FMSP_OFS_CKCTRL, 32'h10);
    wr(`FMSP_OFS_T1RELOAD, 32'hff);
    // Let timer 1 reach its reload before timing bits
    repeat (300) @(posedge clk);
    t_tx(32'hc8, 16);
    // Timer 2 preloaded while stopped, then selected both ways
    wr(`FMSP_OFS_T2RELOAD, 32'hffff);
    wr(`FMSP_OFS_T2CTRL, 32'h30);
    t_tx(32'h40, 32);
    rx_case(8'h81, 1'b1, 32'h81, 32'h55);
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up;
  end
endmodule
`default_nettype wire
